// File: hw/ifd_decoder.v
// Notes on behaviour
// - split 16-bit word into nibble fields by format
// - opcode bits pick each operand's addressing kind
// - single-register field at 11:8, control register other
// - register branch passes source field for pc add
// - multiply-accumulate: both fields post-increment sources
// - 4-bit displacement zero-extended, scaled by size
// - logical immediates zero-extended
// - move, add, compare-equal immediates sign-extended
`include "ifd_regs.vh"
module ifd_decoder (
  input  wire        core_clk,        // cpu clock
  input  wire        reset_n,         // synchronous reset, active low
  input  wire        fetch_valid,     // instruction word present
  input  wire [15:0] fetch_word,      // instruction word from fetch
  output reg         dec_valid,       // decoded fields valid
  output reg  [15:0] dec_word,        // word that was decoded
  output reg  [3:0]  dec_opcode,      // top opcode nibble
  output reg  [3:0]  dec_format,      // instruction format
  output reg  [3:0]  dec_src_reg,     // source register number
  output reg  [3:0]  dec_src_mode,    // source addressing kind
  output reg  [3:0]  dec_src2_reg,    // second source register
  output reg  [3:0]  dec_src2_mode,   // second source addressing kind
  output reg  [3:0]  dec_dst_reg,     // destination register number
  output reg  [3:0]  dec_dst_mode,    // destination addressing kind
  output reg  [1:0]  dec_size,        // access size
  output reg  [31:0] dec_operand      // extended immediate/displacement
);
  // ----------------------------------------------------------------
  // field slices
  // ----------------------------------------------------------------
  wire [3:0] op_hi;   // opcode nibble 15:12
  wire [3:0] fld_n;   // field 11:8
  wire [3:0] fld_m;   // field 7:4
  wire [3:0] fld_lo;  // field 3:0
  wire [31:0] ext_value;  // extender result
  assign op_hi  = fetch_word[`IFD_OP_MSB:`IFD_OP_LSB];
  assign fld_n  = fetch_word[`IFD_N_MSB:`IFD_N_LSB];
  assign fld_m  = fetch_word[`IFD_M_MSB:`IFD_M_LSB];
  assign fld_lo = fetch_word[`IFD_LO_MSB:`IFD_LO_LSB];
  // decode results, combinational
  reg [3:0] next_format, next_src_reg, next_src_mode;
  reg [3:0] next_src2_reg, next_src2_mode;
  reg [3:0] next_dst_reg, next_dst_mode;
  reg [1:0] next_size;
  reg [2:0] next_ext;

  // ----------------------------------------------------------------
  // format and operand decode
  // ----------------------------------------------------------------
  // default: source is field 7:4, destination is field 11:8
  always @* begin
    next_format    = `IFD_FMT_ZERO;
    next_src_reg   = fld_m;
    next_src_mode  = `IFD_AM_NONE;
    next_src2_reg  = `IFD_REG_ZERO;
    next_src2_mode = `IFD_AM_NONE;
    next_dst_reg   = fld_n;
    next_dst_mode  = `IFD_AM_NONE;
    next_size      = `IFD_SZ_LONG;
    next_ext       = `IFD_EX_NONE;
    case (op_hi)
      4'h0: begin
        case (fld_lo)
          4'h2, 4'h9, 4'hA: begin  // t bit or control/system reg into rn
            next_format   = `IFD_FMT_N;
            next_src_mode = fld_lo[0] ? `IFD_AM_NONE : `IFD_AM_CTRL;
            next_dst_mode = `IFD_AM_DIRECT;
          end
          4'h3: begin  // register-relative branch / subroutine
            next_format   = `IFD_FMT_M;
            next_src_reg  = fld_n;
            next_src_mode = `IFD_AM_PC_REG;
            next_dst_mode = `IFD_AM_NONE;
          end
          4'h4, 4'h5, 4'h6, 4'hC, 4'hD, 4'hE: begin  // r0-indexed store or load
            next_format   = `IFD_FMT_NM;
            next_src_mode = fld_lo[3] ? `IFD_AM_INDEXED : `IFD_AM_DIRECT;
            next_dst_mode = fld_lo[3] ? `IFD_AM_DIRECT : `IFD_AM_INDEXED;
            next_size     = fld_lo[1:0];
          end
          4'h7: begin  // register multiply
            next_format   = `IFD_FMT_NM;
            next_src_mode = `IFD_AM_DIRECT;
            next_dst_mode = `IFD_AM_DIRECT;
          end
          4'hF: begin  // long multiply-accumulate
            next_format    = `IFD_FMT_NM;
            next_src_mode  = `IFD_AM_POSTINC;
            next_src2_reg  = fld_n;
            next_src2_mode = `IFD_AM_POSTINC;
            next_dst_mode  = `IFD_AM_ACCUM;
          end
          default: next_format = `IFD_FMT_ZERO;
        endcase
      end
      4'h1, 4'h5: begin  // store / load with 4-bit displacement
        next_format   = `IFD_FMT_NMD;
        next_src_mode = op_hi[2] ? `IFD_AM_REG_DISP : `IFD_AM_DIRECT;
        next_dst_mode = op_hi[2] ? `IFD_AM_DIRECT : `IFD_AM_REG_DISP;
        next_ext      = `IFD_EX_DISP4;
      end
      4'h2: begin  // logic and compare forms unless a store
        next_format   = `IFD_FMT_NM;
        next_src_mode = `IFD_AM_DIRECT;
        next_dst_mode = `IFD_AM_DIRECT;
        if (!fld_lo[3]) begin  // store via @rn or @-rn
          next_dst_mode = fld_lo[2] ? `IFD_AM_PREDEC : `IFD_AM_INDIRECT;
          next_size     = fld_lo[1:0];
        end
      end
      4'h3: begin  // register arithmetic
        next_format   = `IFD_FMT_NM;
        next_src_mode = `IFD_AM_DIRECT;
        next_dst_mode = `IFD_AM_DIRECT;
      end
      4'h4: begin
        case (fld_lo)
          4'hF: begin  // word multiply-accumulate
            next_format    = `IFD_FMT_NM;
            next_src_mode  = `IFD_AM_POSTINC;
            next_src2_reg  = fld_n;
            next_src2_mode = `IFD_AM_POSTINC;
            next_dst_mode  = `IFD_AM_ACCUM;
            next_size      = `IFD_SZ_WORD;
          end
          4'h2, 4'h3: begin  // store control reg via @-rn
            next_format   = `IFD_FMT_N;
            next_src_mode = `IFD_AM_CTRL;
            next_dst_mode = `IFD_AM_PREDEC;
          end
          4'h6, 4'h7, 4'hA, 4'hE: begin  // load control reg from rm or @rm+
            next_format   = `IFD_FMT_M;
            next_src_reg  = fld_n;
            next_src_mode = fld_lo[3] ? `IFD_AM_DIRECT : `IFD_AM_POSTINC;
            next_dst_mode = `IFD_AM_CTRL;
          end
          4'hB: begin  // jump forms through @rm
            next_format   = `IFD_FMT_M;
            next_src_reg  = fld_n;
            next_src_mode = `IFD_AM_INDIRECT;
          end
          default: begin  // shifts, rotates, decrements on rn
            next_format   = `IFD_FMT_N;
            next_dst_mode = `IFD_AM_DIRECT;
          end
        endcase
      end
      4'h6: begin  // register moves unless a load
        next_format   = `IFD_FMT_NM;
        next_src_mode = `IFD_AM_DIRECT;
        next_dst_mode = `IFD_AM_DIRECT;
        if (!fld_lo[3]) begin  // load via @rm or @rm+
          next_src_mode = fld_lo[2] ? `IFD_AM_POSTINC : `IFD_AM_INDIRECT;
          next_size     = fld_lo[1:0];
        end
      end
      4'h7, 4'hE: begin  // add / move signed immediate to rn
        next_format   = `IFD_FMT_NI;
        next_src_mode = `IFD_AM_IMM;
        next_dst_mode = `IFD_AM_DIRECT;
        next_ext      = `IFD_EX_SIGN8;
      end
      4'h8: begin
        case (fld_n)
          4'h0, 4'h1: begin  // r0 store, 4-bit disp on field 7:4
            next_format   = `IFD_FMT_ND4;
            next_src_reg  = `IFD_REG_ZERO;
            next_src_mode = `IFD_AM_DIRECT;
            next_dst_reg  = fld_m;
            next_dst_mode = `IFD_AM_REG_DISP;
            next_size     = fld_n[1:0];
            next_ext      = `IFD_EX_DISP4;
          end
          4'h4, 4'h5: begin  // r0 load, 4-bit disp on field 7:4
            next_format   = `IFD_FMT_MD;
            next_src_mode = `IFD_AM_REG_DISP;
            next_dst_reg  = `IFD_REG_ZERO;
            next_dst_mode = `IFD_AM_DIRECT;
            next_size     = fld_n[1:0];
            next_ext      = `IFD_EX_DISP4;
          end
          4'h8: begin  // compare-equal with r0
            next_format   = `IFD_FMT_I;
            next_src_mode = `IFD_AM_IMM;
            next_dst_reg  = `IFD_REG_ZERO;
            next_dst_mode = `IFD_AM_DIRECT;
            next_ext      = `IFD_EX_SIGN8;
          end
          4'h9, 4'hB, 4'hD, 4'hF: begin  // conditional branches
            next_format   = `IFD_FMT_D;
            next_dst_mode = `IFD_AM_PC_REL;
            next_ext      = `IFD_EX_REL8;
          end
          default: next_format = `IFD_FMT_ZERO;
        endcase
      end
      4'h9, 4'hD: begin  // pc-relative load into rn
        next_format   = `IFD_FMT_ND8;
        next_src_mode = `IFD_AM_PC_DISP;
        next_dst_mode = `IFD_AM_DIRECT;
        next_size     = op_hi[2] ? `IFD_SZ_LONG : `IFD_SZ_WORD;
        next_ext      = `IFD_EX_DISP8;
      end
      4'hA, 4'hB: begin  // 12-bit pc-relative branch
        next_format   = `IFD_FMT_D12;
        next_dst_mode = `IFD_AM_PC_REL;
        next_ext      = `IFD_EX_REL12;
      end
      4'hC: begin
        next_src_reg = `IFD_REG_ZERO;
        next_dst_reg = `IFD_REG_ZERO;
        case (fld_n[3:2])
          2'h0: begin
            if (fld_n[1:0] == 2'h3) begin  // software trap
              next_format   = `IFD_FMT_I;
              next_src_mode = `IFD_AM_IMM;
              next_ext      = `IFD_EX_TRAP8;
            end else begin  // r0 store via gbr displacement
              next_format   = `IFD_FMT_D;
              next_src_mode = `IFD_AM_DIRECT;
              next_dst_mode = `IFD_AM_GBR_DISP;
              next_size     = fld_n[1:0];
              next_ext      = `IFD_EX_DISP8;
            end
          end
          2'h1: begin
            next_format   = `IFD_FMT_D;
            next_dst_mode = `IFD_AM_DIRECT;
            next_ext      = `IFD_EX_DISP8;
            if (fld_n[1:0] == 2'h3) begin  // effective address to r0
              next_src_mode = `IFD_AM_PC_DISP;
            end else begin  // r0 load via gbr displacement
              next_src_mode = `IFD_AM_GBR_DISP;
              next_size     = fld_n[1:0];
            end
          end
          default: begin  // logical immediate on r0 or on byte at r0+gbr
            next_format   = `IFD_FMT_I;
            next_src_mode = `IFD_AM_IMM;
            next_dst_mode = fld_n[2] ? `IFD_AM_GBR_INDEX : `IFD_AM_DIRECT;
            next_size     = fld_n[2] ? `IFD_SZ_BYTE : `IFD_SZ_LONG;
            next_ext      = `IFD_EX_ZERO8;
          end
        endcase
      end
      default: next_format = `IFD_FMT_ZERO;
    endcase
  end

  // ----------------------------------------------------------------
  // operand widening
  // ----------------------------------------------------------------
  ifd_extend u_extend (
    .ext_kind  (next_ext),
    .ext_size  (next_size),
    .ext_field (fetch_word[`IFD_D12_MSB:0]),
    .ext_value (ext_value)
  );

  // ----------------------------------------------------------------
  // output stage: one register stage, fields held when idle
  // ----------------------------------------------------------------
  always @(posedge core_clk) begin
    if (!reset_n) begin
      dec_valid     <= 1'b0;
      dec_word      <= `IFD_RST_WORD;
      dec_opcode    <= `IFD_FMT_ZERO;
      dec_format    <= `IFD_FMT_ZERO;
      dec_src_reg   <= `IFD_REG_ZERO;
      dec_src_mode  <= `IFD_AM_NONE;
      dec_src2_reg  <= `IFD_REG_ZERO;
      dec_src2_mode <= `IFD_AM_NONE;
      dec_dst_reg   <= `IFD_REG_ZERO;
      dec_dst_mode  <= `IFD_AM_NONE;
      dec_size      <= `IFD_SZ_BYTE;
      dec_operand   <= `IFD_RST_DATA;
    end else begin
      dec_valid <= fetch_valid;
      if (fetch_valid) begin  // capture only real words
        dec_word      <= fetch_word;
        dec_opcode    <= op_hi;
        dec_format    <= next_format;
        dec_src_reg   <= next_src_reg;
        dec_src_mode  <= next_src_mode;
        dec_src2_reg  <= next_src2_reg;
        dec_src2_mode <= next_src2_mode;
        dec_dst_reg   <= next_dst_reg;
        dec_dst_mode  <= next_dst_mode;
        dec_size      <= next_size;
        dec_operand   <= ext_value;
      end
    end
  end
endmodule

// File: hw/ifd_regs.vh
`ifndef IFD_REGS_VH
`define IFD_REGS_VH
// ----------------------------------------------------------------
// instruction word field positions
// ----------------------------------------------------------------
`define IFD_OP_MSB        15
`define IFD_OP_LSB        12
`define IFD_N_MSB         11
`define IFD_N_LSB         8
`define IFD_M_MSB         7
`define IFD_M_LSB         4
`define IFD_LO_MSB        3
`define IFD_LO_LSB        0
`define IFD_D12_MSB       11
`define IFD_WORD_W        16
`define IFD_DATA_W        32
// ----------------------------------------------------------------
// register numbers and reset values
// ----------------------------------------------------------------
`define IFD_REG_ZERO      4'h0
`define IFD_RST_WORD      16'h0000
`define IFD_RST_DATA      32'h00000000
// ----------------------------------------------------------------
// instruction formats
// ----------------------------------------------------------------
`define IFD_FMT_ZERO      4'h0
`define IFD_FMT_N         4'h1
`define IFD_FMT_M         4'h2
`define IFD_FMT_NM        4'h3
`define IFD_FMT_MD        4'h4
`define IFD_FMT_ND4       4'h5
`define IFD_FMT_NMD       4'h6
`define IFD_FMT_D         4'h7
`define IFD_FMT_D12       4'h8
`define IFD_FMT_ND8       4'h9
`define IFD_FMT_I         4'hA
`define IFD_FMT_NI        4'hB
// ----------------------------------------------------------------
// operand addressing interpretation
// ----------------------------------------------------------------
`define IFD_AM_NONE       4'h0
`define IFD_AM_DIRECT     4'h1
`define IFD_AM_INDIRECT   4'h2
`define IFD_AM_POSTINC    4'h3
`define IFD_AM_PREDEC     4'h4
`define IFD_AM_INDEXED    4'h5
`define IFD_AM_REG_DISP   4'h6
`define IFD_AM_GBR_DISP   4'h7
`define IFD_AM_GBR_INDEX  4'h8
`define IFD_AM_PC_DISP    4'h9
`define IFD_AM_PC_REL     4'hA
`define IFD_AM_PC_REG     4'hB
`define IFD_AM_IMM        4'hC
`define IFD_AM_CTRL       4'hD
`define IFD_AM_ACCUM      4'hE
// ----------------------------------------------------------------
// access sizes
// ----------------------------------------------------------------
`define IFD_SZ_BYTE       2'h0
`define IFD_SZ_WORD       2'h1
`define IFD_SZ_LONG       2'h2
// ----------------------------------------------------------------
// immediate / displacement extension kinds
// ----------------------------------------------------------------
`define IFD_EX_NONE       3'h0
`define IFD_EX_ZERO8      3'h1
`define IFD_EX_SIGN8      3'h2
`define IFD_EX_TRAP8      3'h3
`define IFD_EX_DISP4      3'h4
`define IFD_EX_DISP8      3'h5
`define IFD_EX_REL8       3'h6
`define IFD_EX_REL12      3'h7
`define IFD_TRAP_SHIFT    2
`define IFD_REL_SHIFT     1
`endif

// File: hw/ifd_extend.v
`include "ifd_regs.vh"
// ----------------------------------------------------------------
// operand extender: widens immediate and displacement fields
// ----------------------------------------------------------------
module ifd_extend (
  input  wire [2:0]  ext_kind,   // extension kind
  input  wire [1:0]  ext_size,   // access size for scaling
  input  wire [11:0] ext_field,  // low 12 bits of the word
  output reg  [31:0] ext_value   // widened operand
);
  wire [31:0] zero4;   // zero-extended 4-bit field
  wire [31:0] zero8;   // zero-extended 8-bit field
  wire [31:0] sign8;   // sign-extended 8-bit field
  wire [31:0] sign12;  // sign-extended 12-bit field

  assign zero4  = {28'h0000000, ext_field[3:0]};
  assign zero8  = {24'h000000, ext_field[7:0]};
  assign sign8  = {{24{ext_field[7]}}, ext_field[7:0]};
  assign sign12 = {{20{ext_field[11]}}, ext_field[11:0]};

  // scaling by size is a plain shift: byte 0, word 1, long 2
  always @* begin
    case (ext_kind)
      `IFD_EX_ZERO8: ext_value = zero8;
      `IFD_EX_SIGN8: ext_value = sign8;
      `IFD_EX_TRAP8: ext_value = zero8 << `IFD_TRAP_SHIFT;
      `IFD_EX_DISP4: ext_value = zero4 << ext_size;
      `IFD_EX_DISP8: ext_value = zero8 << ext_size;
      `IFD_EX_REL8:  ext_value = sign8 << `IFD_REL_SHIFT;
      `IFD_EX_REL12: ext_value = sign12 << `IFD_REL_SHIFT;
      default:       ext_value = `IFD_RST_DATA;
    endcase
  end
endmodule

// File: sim/ifd_decoder_asserts.sv
`include "ifd_regs.vh"
// ----------------------------------------------------------------
// port checker for the decode stage
// ----------------------------------------------------------------
module ifd_decoder_asserts (
  input wire        core_clk,
  input wire        reset_n,
  input wire        fetch_valid,
  input wire [15:0] fetch_word,
  input wire        dec_valid,
  input wire [15:0] dec_word,
  input wire [3:0]  dec_opcode,
  input wire [3:0]  dec_format,
  input wire [3:0]  dec_src_reg,
  input wire [3:0]  dec_src_mode,
  input wire [3:0]  dec_src2_reg,
  input wire [3:0]  dec_src2_mode,
  input wire [3:0]  dec_dst_reg,
  input wire [3:0]  dec_dst_mode,
  input wire [1:0]  dec_size,
  input wire [31:0] dec_operand
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  // reset wins over any offered word
  a_reset_clears_all: assert property (disable iff (1'b0)
    !reset_n |=> !dec_valid && dec_operand == 32'h0 && dec_format == 4'h0)
    else $error("outputs not cleared by reset");
  a_valid_follows_take: assert property (reset_n && fetch_valid |=> dec_valid)
    else $error("accepted word gave no valid");
  a_idle_no_valid: assert property (!fetch_valid |=> !dec_valid)
    else $error("valid without a word");
  // fields must hold while nothing new is taken
  a_idle_fields_hold: assert property (reset_n && !fetch_valid |=>
    $stable(dec_word) && $stable(dec_operand) && $stable(dec_format))
    else $error("fields moved while idle");
  a_word_opcode_split: assert property (fetch_valid |=>
    dec_word == $past(fetch_word) && dec_opcode == $past(fetch_word[15:12]))
    else $error("word or opcode nibble wrong");
  a_logic_imm_zero: assert property (fetch_valid && fetch_word[15:10] == 6'h32
    |=> dec_operand == {24'h0, $past(fetch_word[7:0])})
    else $error("logical immediate not zero-extended");
  a_arith_imm_sign: assert property (fetch_valid && fetch_word[15:12] == 4'h7
    |=> dec_operand == {{24{$past(fetch_word[7])}}, $past(fetch_word[7:0])})
    else $error("add immediate not sign-extended");
  a_disp4_long_scale: assert property (fetch_valid && fetch_word[15:12] == 4'h5
    |=> dec_operand == {26'h0, $past(fetch_word[3:0]), 2'h0})
    else $error("long disp4 not scaled by four");
  a_disp12_sign_two: assert property (fetch_valid && fetch_word[15:12] == 4'hA
    |=> dec_operand == {{19{$past(fetch_word[11])}}, $past(fetch_word[11:0]), 1'b0})
    else $error("disp12 not sign-extended and doubled");
  a_mac_two_sources: assert property (fetch_valid && fetch_word[15:12] == 4'h4
    && fetch_word[3:0] == 4'hF |=> dec_src_mode == `IFD_AM_POSTINC
    && dec_src2_mode == `IFD_AM_POSTINC && dec_src2_reg == $past(fetch_word[11:8]))
    else $error("multiply-accumulate sources wrong");
  a_branch_reg_pass: assert property (fetch_valid && fetch_word[15:12] == 4'h0
    && fetch_word[7:0] == 8'h23 |=> dec_src_reg == $past(fetch_word[11:8])
    && dec_src_mode == `IFD_AM_PC_REG)
    else $error("register branch source wrong");
  c_back_to_back: cover property (fetch_valid ##1 fetch_valid);
  c_mac_seen: cover property (dec_valid && dec_dst_mode == `IFD_AM_ACCUM);
  c_sign_neg: cover property (dec_valid && dec_operand[31]);
endmodule

bind ifd_decoder ifd_decoder_asserts u_chk (
  .core_clk(core_clk), .reset_n(reset_n), .fetch_valid(fetch_valid),
  .fetch_word(fetch_word), .dec_valid(dec_valid), .dec_word(dec_word),
  .dec_opcode(dec_opcode), .dec_format(dec_format), .dec_src_reg(dec_src_reg),
  .dec_src_mode(dec_src_mode), .dec_src2_reg(dec_src2_reg),
  .dec_src2_mode(dec_src2_mode), .dec_dst_reg(dec_dst_reg),
  .dec_dst_mode(dec_dst_mode), .dec_size(dec_size), .dec_operand(dec_operand));

// File: sim/ifd_fetch_model.sv
// ----------------------------------------------------------------
// fetch unit stand-in: hands words over at rising edges
// ----------------------------------------------------------------
module ifd_fetch_model (
  input  wire         core_clk,
  output logic        fetch_valid,
  output logic [15:0] fetch_word
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    fetch_valid = 1'b0;
    fetch_word  = 16'hA5A5;
  end
  // present one word from the next edge on
  task automatic offer(input logic [15:0] w);
    @(posedge core_clk);
    fetch_valid <= 1'b1;
    fetch_word  <= w;
  endtask
  // drop valid; invert the word so a stale value is never mistaken
  task automatic idle();
    @(posedge core_clk);
    fetch_valid <= 1'b0;
    fetch_word  <= ~fetch_word;
  endtask
endmodule

// File: sim/ifd_decoder_bench.sv
`include "ifd_regs.vh"
// ----------------------------------------------------------------
// decode stage bench
// ----------------------------------------------------------------
module ifd_decoder_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        core_clk;
  logic        reset_n;
  wire         fetch_valid;
  wire  [15:0] fetch_word;
  wire         dec_valid;
  wire  [15:0] dec_word;
  wire  [3:0]  dec_opcode, dec_format, dec_src_reg, dec_src_mode;
  wire  [3:0]  dec_src2_reg, dec_src2_mode, dec_dst_reg, dec_dst_mode;
  wire  [1:0]  dec_size;
  wire  [31:0] dec_operand;
  int          mismatches;
  int          comparisons;
  logic [15:0] sgn_words [3] = '{16'h7380, 16'hE5F0, 16'h88FE};

  ifd_fetch_model u_fetch (.core_clk(core_clk), .fetch_valid(fetch_valid),
    .fetch_word(fetch_word));
  ifd_decoder u_dut (.core_clk(core_clk), .reset_n(reset_n), .fetch_valid(fetch_valid),
    .fetch_word(fetch_word), .dec_valid(dec_valid), .dec_word(dec_word),
    .dec_opcode(dec_opcode), .dec_format(dec_format), .dec_src_reg(dec_src_reg),
    .dec_src_mode(dec_src_mode), .dec_src2_reg(dec_src2_reg),
    .dec_src2_mode(dec_src2_mode), .dec_dst_reg(dec_dst_reg),
    .dec_dst_mode(dec_dst_mode), .dec_size(dec_size), .dec_operand(dec_operand));

  // 200 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  // ----------------------------------------------------------------
  // shared helpers
  // ----------------------------------------------------------------
  task automatic summarize();
    if (mismatches == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t field got %h expected %h", $time, got, exp);
    end
  endtask
  // one word through, checked 1 ns after the edge that takes it
  task automatic dec1(input logic [15:0] w);
    u_fetch.offer(w);
    u_fetch.idle();
    #1;
    chk({31'h0, dec_valid}, 32'h1);
    chk({16'h0, dec_word}, {16'h0, w});
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_walk();
    dec1(16'h7F80);
    chk(dec_format, `IFD_FMT_NI);
    chk(dec_opcode, 32'h7);
    chk(dec_src_mode, `IFD_AM_IMM);
    chk(dec_dst_reg, 32'hF);
    chk(dec_dst_mode, `IFD_AM_DIRECT);
    chk(dec_operand, 32'hFFFFFF80);
  endtask
  task automatic t_imm();
    for (int i = 0; i < 4; i++) begin
      dec1({8'hC8 + 8'(i), 8'h9C});
      chk(dec_operand, 32'h0000009C);
    end
    foreach (sgn_words[i]) begin
      dec1(sgn_words[i]);
      chk(dec_operand, {{24{sgn_words[i][7]}}, sgn_words[i][7:0]});
    end
  endtask
  task automatic t_mac();
    dec1(16'h4A1F);
    chk(dec_src_reg, 32'h1);
    chk(dec_src_mode, `IFD_AM_POSTINC);
    chk(dec_src2_reg, 32'hA);
    chk(dec_src2_mode, `IFD_AM_POSTINC);
    chk(dec_dst_mode, `IFD_AM_ACCUM);
    chk(dec_size, `IFD_SZ_WORD);
  endtask
  task automatic t_branch();
    dec1(16'h0323);
    chk(dec_format, `IFD_FMT_M);
    chk(dec_src_reg, 32'h3);
    chk(dec_src_mode, `IFD_AM_PC_REG);
    dec1(16'hA800);
    chk(dec_operand, 32'hFFFFF000);
    dec1(16'hC303);
    chk(dec_operand, 32'h0000000C);
  endtask
  task automatic t_single();
    dec1(16'h4503);
    chk(dec_format, `IFD_FMT_N);
    chk(dec_dst_reg, 32'h5);
    chk(dec_dst_mode, `IFD_AM_PREDEC);
    chk(dec_src_mode, `IFD_AM_CTRL);
    dec1(16'h4607);
    chk(dec_src_reg, 32'h6);
    chk(dec_src_mode, `IFD_AM_POSTINC);
    chk(dec_dst_mode, `IFD_AM_CTRL);
  endtask
  task automatic t_disp();
    dec1(16'h5125);
    chk(dec_format, `IFD_FMT_NMD);
    chk(dec_src_reg, 32'h2);
    chk(dec_src_mode, `IFD_AM_REG_DISP);
    chk(dec_operand, 32'h00000014);
    dec1(16'h8115);
    chk(dec_dst_reg, 32'h1);
    chk(dec_dst_mode, `IFD_AM_REG_DISP);
    chk(dec_operand, 32'h0000000A);
    dec1(16'h8415);
    chk(dec_size, `IFD_SZ_BYTE);
    chk(dec_operand, 32'h00000005);
    dec1(16'hC512);
    chk(dec_src_mode, `IFD_AM_GBR_DISP);
    chk(dec_operand, 32'h00000024);
    dec1(16'hD310);
    chk(dec_src_mode, `IFD_AM_PC_DISP);
    chk(dec_operand, 32'h00000040);
    dec1(16'h2312);
    chk(dec_dst_mode, `IFD_AM_INDIRECT);
    chk(dec_size, `IFD_SZ_LONG);
    dec1(16'h0126);
    chk(dec_src_mode, `IFD_AM_DIRECT);
    chk(dec_dst_mode, `IFD_AM_INDEXED);
  endtask
  // two words on consecutive edges, then fields must hold
  task automatic t_b2b();
    u_fetch.offer(16'hC8F0);
    u_fetch.offer(16'h7301);
    #1;
    chk(dec_operand, 32'h000000F0);
    u_fetch.idle();
    #1;
    chk(dec_operand, 32'h00000001);
    @(posedge core_clk);
    #1;
    chk({31'h0, dec_valid}, 32'h0);
    chk({16'h0, dec_word}, 32'h7301);
  endtask
  // one reset edge in mid-run clears everything
  task automatic t_midreset();
    dec1(16'h7F80);
    @(posedge core_clk);
    reset_n <= 1'b0;
    @(posedge core_clk);
    reset_n <= 1'b1;
    #1;
    chk(dec_operand, 32'h0);
    chk({16'h0, dec_word}, 32'h0);
    dec1(16'hC8FF);
    chk(dec_operand, 32'h000000FF);
  endtask
  // ----------------------------------------------------------------
  // main sequence and hang guard
  // ----------------------------------------------------------------
  initial begin
    mismatches = 0;
    comparisons = 0;
    reset_n = 1'b0;
    repeat (8) @(posedge core_clk);
    #1;
    chk({31'h0, dec_valid}, 32'h0);
    chk(dec_format, `IFD_FMT_ZERO);
    @(posedge core_clk);
    reset_n <= 1'b1;
    t_walk();
    t_imm();
    t_mac();
    t_branch();
    t_single();
    t_disp();
    t_b2b();
    t_midreset();
    summarize();
  end
  initial begin
    repeat (5000) @(posedge core_clk);
    mismatches++;
    summarize();
  end
endmodule
